// ---- hw/tag2_consts.svh ----
/*
  Shared constants of the type 2 tag command link: command codes, arguments,
  answer codes and timing counts.
  Assumes a 125 MHz core clock on both ends.
*/
// Summary of operation
// - Code 95h; argument 70h selects, 20h-67h anticollision
// - Level-two commands only honoured in ready2
// - Anticollision answers remaining second UID part bytes
// - Select matching second UID half answers 00h
// - Select still works despite a CRC error
// - Read 30h, pages 00h-29h, else NAK
// - Read returns four pages, wrapping 29h to 00h
// - Halt 50h 00h: silent halt, else NAK
// - Halt still works despite a parity error
// - Write A2h, pages 02h-29h, four bytes, ACK/NAK
// - Compatibility write A0h stores first four bytes
// - Reader sends zeros in bytes four to fifteen
// - Reader waits 71 us min, 5/10 ms max; the code only flags earlier answers in compatibility writes
// - Answers: Ah ACK, 1h integrity NAK, 0h other
// - Every NAK resets the protocol state
`ifndef TAG2_CONSTS_SVH
`define TAG2_CONSTS_SVH

// ==========================================================
// Command codes and arguments
`define CMD_CL2 8'h95
`define ARG_SELECT 8'h70
`define ARG_AC_FULL 8'h20
`define ARG_AC_HI 8'h67
`define SAK_CL2 8'h00
`define CMD_READ 8'h30
`define CMD_HALT 8'h50
`define ARG_HALT 8'h00
`define CMD_WRITE 8'hA2
`define CMD_CWRITE 8'hA0
`define CASCADE_MARKER_BYTE 8'h88
`define PAGE_LAST 8'h29
`define PAGE_WR_FIRST 8'h02
`define PAGE_COUNT 42
`define WRITE_LEN 5'h06
`define CWRITE_LEN 5'h02
`define CWRITE_DATA_LEN 5'h10
`define CWRITE_KEEP 5'h04

// ==========================================================
// Answer codes
`define ANS_ACK 4'hA
`define ANS_NAK_CRC 4'h1
`define ANS_NAK_OTHER 4'h0

// ==========================================================
// Timing
`define CLK_PERIOD_NS 8
`define LINK_PERIOD_NS 64
`define LINK_HALF_CYC (`LINK_PERIOD_NS / `CLK_PERIOD_NS / 2)
`define T_ACK_MIN_US 71
`define T_TO1_MS 5
`define T_TO2_MS 10
`define T_ACK_MIN_CYC ((`T_ACK_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_TO1_CYC ((`T_TO1_MS * 1000000) / `CLK_PERIOD_NS)
`define T_TO2_CYC ((`T_TO2_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// ---- hw/tag2_link_if.sv ----
/*
  Byte-wide link between the reader end and the tag end.
  Assumes the reader makes link_clk and changes its signals on the falling edge;
  the tag does the same with its own signals; the tag samples near the rising edge, the reader at the falling edge.
*/
`timescale 1ns/1ps
interface tag2_link_if;
  logic link_clk;
  logic rd_valid;
  logic [7:0] rd_data;
  logic rd_last;
  logic rd_par_err;
  logic rd_crc_err;
  logic tg_valid;
  logic [7:0] tg_data;
  logic tg_last;
  logic tg_nibble;
  modport tag (input link_clk, input rd_valid, input rd_data, input rd_last, input rd_par_err,
               input rd_crc_err, output tg_valid, output tg_data, output tg_last, output tg_nibble);
  modport reader (output link_clk, output rd_valid, output rd_data, output rd_last, output rd_par_err,
                  output rd_crc_err, input tg_valid, input tg_data, input tg_last, input tg_nibble);
endinterface

// ---- hw/tag2_pkg.sv ----
/*
  Types shared by both ends of the tag link.
  Assumes nothing beyond a SystemVerilog tool.
*/
package tag2_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_READY2, ST_ACTIVE, ST_HALT, ST_CWR_DATA} tag_state_t;
  typedef enum logic {RS_SEND, RS_WAIT} rdr_state_t;
endpackage

// ---- hw/tag2_reader_end.sv ----
/*
  Reader end: makes the link clock, sends command frames, collects answers
  and checks the answer timing of the two-phase compatibility write.
  Assumes a byte stream from the user side and the tag end on the link.
*/
`timescale 1ns/1ps
`include "tag2_consts.svh"

module tag2_reader_end #(
  parameter int LINK_HALF = `LINK_HALF_CYC,
  parameter int ACK_MIN_CYC = `T_ACK_MIN_CYC,
  parameter int TO1_CYC = `T_TO1_CYC,
  parameter int TO2_CYC = `T_TO2_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Link
  tag2_link_if.reader lk,
  // Command bytes
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_last,
  input wire logic cmd_par_err,
  input wire logic cmd_crc_err,
  // Answers
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_last,
  output logic rsp_nibble,
  output logic rsp_early,
  output logic rsp_timeout
);
  tag2_pkg::rdr_state_t state;
  logic [15:0] div_cnt;
  logic fall_evt, pre_fall;
  logic [10:0] sync1, sync2;
  logic [4:0] byte_idx;
  logic ph1, ph2, ph2_armed;
  logic [31:0] wait_cnt;

  // Link clock drops at the end of its high half; data moves on that edge
  assign fall_evt = lk.link_clk && div_cnt == 16'(LINK_HALF - 1);
  assign pre_fall = lk.link_clk && div_cnt == 16'(LINK_HALF - 2);

  // ==========================================================
  // Clock divider
  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_cnt <= '0;
      lk.link_clk <= 1'b0;
    end else if (div_cnt == 16'(LINK_HALF - 1)) begin
      div_cnt <= '0;
      lk.link_clk <= !lk.link_clk;
    end else begin
      div_cnt <= div_cnt + 16'd1;
    end
  end

  // Tag outputs come from another clock domain
  always_ff @(posedge core_clk) begin
    sync1 <= {lk.tg_valid, lk.tg_last, lk.tg_nibble, lk.tg_data};
    sync2 <= sync1;
  end

  // ==========================================================
  // Sending
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmd_ready <= 1'b0;
      lk.rd_valid <= 1'b0;
      lk.rd_data <= '0;
      lk.rd_last <= 1'b0;
      lk.rd_par_err <= 1'b0;
      lk.rd_crc_err <= 1'b0;
    end else begin
      cmd_ready <= pre_fall && state == tag2_pkg::RS_SEND;
      if (fall_evt) begin
        lk.rd_valid <= cmd_ready && cmd_valid;
        // Padding bytes of the data phase go out as zeros
        lk.rd_data <= (ph2 && byte_idx >= `CWRITE_KEEP) ? 8'h00 : cmd_data;
        lk.rd_last <= cmd_ready && cmd_valid && cmd_last;
        lk.rd_par_err <= cmd_ready && cmd_valid && cmd_par_err;
        lk.rd_crc_err <= cmd_ready && cmd_valid && cmd_crc_err;
      end
    end
  end

  // ==========================================================
  // Frame sequencing, answer collection and timeouts
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= tag2_pkg::RS_SEND;
      byte_idx <= '0;
      ph1 <= 1'b0;
      ph2 <= 1'b0;
      ph2_armed <= 1'b0;
      wait_cnt <= '0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      rsp_last <= 1'b0;
      rsp_nibble <= 1'b0;
      rsp_early <= 1'b0;
      rsp_timeout <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      rsp_timeout <= 1'b0;
      case (state)
        tag2_pkg::RS_SEND: begin
          if (fall_evt && cmd_ready && cmd_valid) begin
            byte_idx <= cmd_last ? '0 : byte_idx + 5'd1;
            if (byte_idx == '0) begin
              ph2 <= ph2_armed;
              ph1 <= !ph2_armed && cmd_data == `CMD_CWRITE;
              ph2_armed <= 1'b0;
            end
            if (cmd_last) begin
              state <= tag2_pkg::RS_WAIT;
              wait_cnt <= '0;
            end
          end
        end
        tag2_pkg::RS_WAIT: begin
          wait_cnt <= wait_cnt + 32'd1;
          if (fall_evt && sync2[10]) begin
            rsp_valid <= 1'b1;
            rsp_data <= sync2[7:0];
            rsp_last <= sync2[9];
            rsp_nibble <= sync2[8];
            rsp_early <= (ph1 || ph2) && wait_cnt < 32'(ACK_MIN_CYC);
            if (sync2[9]) begin
              state <= tag2_pkg::RS_SEND;
              ph2_armed <= ph1 && sync2[8] && sync2[3:0] == `ANS_ACK;
              ph1 <= 1'b0;
              ph2 <= 1'b0;
            end
          end else if (wait_cnt >= 32'(ph2 ? TO2_CYC : TO1_CYC)) begin
            rsp_timeout <= 1'b1;
            state <= tag2_pkg::RS_SEND;
            ph1 <= 1'b0;
            ph2 <= 1'b0;
          end
        end
        default: begin
          state <= tag2_pkg::RS_SEND;
        end
      endcase
    end
  end
endmodule

// ---- hw/tag2_tag_end.sv ----
/*
  Tag end: answer FIFO and the command decoder with its page memory.
  Assumes the link of tag2_link_if with the reader making link_clk; CRC and
  parity are checked by the framing layer and arrive as flags with each byte.
*/
`timescale 1ns/1ps
`include "tag2_consts.svh"

module tag2_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic push;
  logic pop;

  assign in_ready = (cnt != (AW+1)'(DEPTH));
  assign out_valid = (cnt != '0);
  assign out_data = mem[rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
      end
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module tag2_tag_end #(
  parameter logic [55:0] UID = 56'h11_2233_4455_6677, // Arbitrary value
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Link
  tag2_link_if.tag lk,
  // User side
  input wire logic wake,
  output logic active,
  output logic halted
);
  tag2_pkg::tag_state_t state, next_state;
  logic [12:0] sync1, sync2;
  logic clk_d;
  logic rise, fall;
  logic [7:0] rx_buf [18];
  logic [4:0] rx_cnt, rx_len;
  logic rx_par, rx_crc, frame_end;
  logic [31:0] mem [`PAGE_COUNT];
  logic [7:0] resp [16];
  logic [7:0] next_resp [16];
  logic [4:0] next_len, tx_left;
  logic [3:0] tx_idx;
  logic next_nib, resp_nib;
  logic do_wr;
  logic [5:0] wr_page, cwr_page, next_cwr_page;
  logic [31:0] wr_word;
  logic [7:0] cmd, arg;
  logic [7:0] cl2 [5];
  logic f_in_valid, f_in_ready, f_out_valid;
  logic [9:0] f_out_data;

  assign cmd = rx_buf[0];
  assign arg = rx_buf[1];
  assign rise = sync2[12] && !clk_d;
  assign fall = !sync2[12] && clk_d;
  assign cl2[0] = UID[31:24];
  assign cl2[1] = UID[23:16];
  assign cl2[2] = UID[15:8];
  assign cl2[3] = UID[7:0];
  assign cl2[4] = UID[31:24] ^ UID[23:16] ^ UID[15:8] ^ UID[7:0];

  // ==========================================================
  // Receive path: every pin passes two flops first
  always_ff @(posedge core_clk) begin
    sync1 <= {lk.link_clk, lk.rd_valid, lk.rd_last, lk.rd_par_err, lk.rd_crc_err, lk.rd_data};
    sync2 <= sync1;
    clk_d <= sync2[12];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_cnt <= '0;
      rx_len <= '0;
      rx_par <= 1'b0;
      rx_crc <= 1'b0;
      frame_end <= 1'b0;
    end else begin
      frame_end <= 1'b0;
      if (rise && sync2[11]) begin
        if (rx_cnt < 5'd18) begin
          rx_buf[rx_cnt] <= sync2[7:0];
        end
        rx_cnt <= rx_cnt + 5'd1;
        if (sync2[10]) begin
          rx_cnt <= '0;
          rx_len <= rx_cnt + 5'd1;
          rx_par <= sync2[9];
          rx_crc <= sync2[8];
          frame_end <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Command decoder
  always_comb begin
    logic nak;
    logic [3:0] ans;
    logic [2:0] known;
    logic [5:0] pg;
    nak = 1'b0;
    ans = `ANS_NAK_OTHER;
    known = '0;
    pg = '0;
    next_state = state;
    next_len = '0;
    next_nib = 1'b0;
    do_wr = 1'b0;
    wr_page = cwr_page;
    wr_word = {rx_buf[3], rx_buf[2], rx_buf[1], rx_buf[0]};
    next_cwr_page = cwr_page;
    for (int i = 0; i < 16; i++) begin
      next_resp[i] = '0;
    end
    if (wake && (state == tag2_pkg::ST_IDLE || state == tag2_pkg::ST_HALT)) begin
      next_state = tag2_pkg::ST_READY2;
    end
    if (frame_end && tx_left == '0) begin
      case (state)
        tag2_pkg::ST_READY2: begin
          if (cmd == `CMD_CL2 && rx_len >= 5'd2) begin
            if (arg == `ARG_SELECT) begin
              // CRC flag deliberately unused here
              if (rx_len >= 5'd6 && rx_buf[2] == cl2[0] && rx_buf[3] == cl2[1]
                  && rx_buf[4] == cl2[2] && rx_buf[5] == cl2[3]) begin
                next_resp[0] = `SAK_CL2;
                next_len = 5'd1;
                next_state = tag2_pkg::ST_ACTIVE;
              end
            end else if (arg >= `ARG_AC_FULL && arg <= `ARG_AC_HI) begin
              // Partly known bytes are resent whole
              known = 3'(arg[7:4] - 4'd2);
              for (int i = 0; i < 5; i++) begin
                if (i + int'(known) < 5) begin
                  next_resp[i] = cl2[i + int'(known)];
                end
              end
              next_len = 5'd5 - 5'(known);
            end
          end
        end
        tag2_pkg::ST_ACTIVE: begin
          if (cmd == `CMD_CL2) begin
            // Level-two frames are dropped without any answer here
          end else if (rx_par && cmd != `CMD_HALT) begin
            nak = 1'b1;
            ans = `ANS_NAK_CRC;
          end else if (cmd == `CMD_HALT) begin
            if (rx_crc) begin
              nak = 1'b1;
              ans = `ANS_NAK_CRC;
            end else if (arg == `ARG_HALT && rx_len == 5'd2) begin
              next_state = tag2_pkg::ST_HALT;
            end else begin
              nak = 1'b1;
            end
          end else if (rx_crc) begin
            nak = 1'b1;
            ans = `ANS_NAK_CRC;
          end else if (cmd == `CMD_READ && rx_len == 5'd2 && arg <= `PAGE_LAST) begin
            for (int i = 0; i < 16; i++) begin
              pg = 6'(int'(arg[5:0]) + i / 4);
              if (pg > 6'(`PAGE_LAST)) begin
                pg = pg - 6'(`PAGE_COUNT);
              end
              next_resp[i] = mem[pg][8 * (i % 4) +: 8];
            end
            next_len = 5'd16;
          end else if (cmd == `CMD_WRITE && rx_len == `WRITE_LEN
                       && arg >= `PAGE_WR_FIRST && arg <= `PAGE_LAST) begin
            do_wr = 1'b1;
            wr_page = arg[5:0];
            wr_word = {rx_buf[5], rx_buf[4], rx_buf[3], rx_buf[2]};
            ans = `ANS_ACK;
            next_nib = 1'b1;
            next_len = 5'd1;
          end else if (cmd == `CMD_CWRITE && rx_len == `CWRITE_LEN
                       && arg >= `PAGE_WR_FIRST && arg <= `PAGE_LAST) begin
            next_cwr_page = arg[5:0];
            next_state = tag2_pkg::ST_CWR_DATA;
            ans = `ANS_ACK;
            next_nib = 1'b1;
            next_len = 5'd1;
          end else begin
            nak = 1'b1;
          end
        end
        tag2_pkg::ST_CWR_DATA: begin
          if (rx_par || rx_crc) begin
            nak = 1'b1;
            ans = `ANS_NAK_CRC;
          end else if (rx_len != `CWRITE_DATA_LEN) begin
            nak = 1'b1;
          end else begin
            do_wr = 1'b1;
            ans = `ANS_ACK;
            next_nib = 1'b1;
            next_len = 5'd1;
            next_state = tag2_pkg::ST_ACTIVE;
          end
        end
        default: begin
        end
      endcase
      if (nak) begin
        next_nib = 1'b1;
        next_len = 5'd1;
        next_state = tag2_pkg::ST_IDLE;
      end
      if (next_nib) begin
        next_resp[0] = {4'h0, ans};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= tag2_pkg::ST_READY2;
      cwr_page <= '0;
      active <= 1'b0;
      halted <= 1'b0;
    end else begin
      state <= next_state;
      cwr_page <= next_cwr_page;
      active <= (next_state == tag2_pkg::ST_ACTIVE || next_state == tag2_pkg::ST_CWR_DATA);
      halted <= (next_state == tag2_pkg::ST_HALT);
    end
  end

  // ==========================================================
  // Page memory, cleared with the UID pages laid in at reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < `PAGE_COUNT; i++) begin
        mem[i] <= '0;
      end
      mem[0] <= {`CASCADE_MARKER_BYTE ^ UID[55:48] ^ UID[47:40] ^ UID[39:32],
                 UID[39:32], UID[47:40], UID[55:48]};
      mem[1] <= {UID[7:0], UID[15:8], UID[23:16], UID[31:24]};
      mem[2] <= {24'h00_0000, cl2[4]};
    end else if (do_wr) begin
      mem[wr_page] <= wr_word;
    end
  end

  // ==========================================================
  // Answer path; the FIFO stalls the feeder when the link lags
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_left <= '0;
      tx_idx <= '0;
      resp_nib <= 1'b0;
    end else if (next_len != '0) begin
      tx_left <= next_len;
      tx_idx <= '0;
      resp_nib <= next_nib;
      resp <= next_resp;
    end else if (f_in_valid && f_in_ready) begin
      tx_left <= tx_left - 5'd1;
      tx_idx <= tx_idx + 4'd1;
    end
  end

  assign f_in_valid = (tx_left != '0);

  tag2_fifo #(.W(10), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(core_clk),
    .rst(rst),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data({tx_left == 5'd1, resp_nib, resp[tx_idx]}),
    .out_valid(f_out_valid),
    .out_ready(fall),
    .out_data(f_out_data)
  );

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lk.tg_valid <= 1'b0;
      lk.tg_data <= '0;
      lk.tg_last <= 1'b0;
      lk.tg_nibble <= 1'b0;
    end else if (fall) begin
      lk.tg_valid <= f_out_valid;
      lk.tg_data <= f_out_data[7:0];
      lk.tg_last <= f_out_valid && f_out_data[9];
      lk.tg_nibble <= f_out_valid && f_out_data[8];
    end
  end
endmodule

// ---- testbench/tag2_link_props.sv ----
/*
  Checker of the byte link between reader end and tag end.
  Assumes all link signals are flops of the core clock domain and that
  rd_* are stable while link_clk rises.
*/
`timescale 1ns/1ps
module tag2_link_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Reader side
  input wire logic link_clk,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic rd_last,
  input wire logic rd_par_err,
  input wire logic rd_crc_err,
  // Tag side
  input wire logic tg_valid,
  input wire logic [7:0] tg_data,
  input wire logic tg_last,
  input wire logic tg_nibble
);
  logic link_q;
  logic take;
  logic halt_ok;
  logic [4:0] nb;
  logic [4:0] len;
  logic [7:0] cmd0;
  logic [7:0] arg;
  logic par_l;
  logic crc_l;
  logic [8:0] run;

  // ==========================================================
  // Frame decoding helpers
  assign take = link_clk && !link_q && rd_valid;
  // Parity is left out on purpose: a halt must work despite it
  assign halt_ok = cmd0 == 8'h50 && arg == 8'h00 && len == 5'h02 && !crc_l;

  always_ff @(posedge core_clk) begin
    link_q <= link_clk;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      nb <= 5'h00;
      len <= 5'h00;
      cmd0 <= 8'h00;
      arg <= 8'h00;
      par_l <= 1'b0;
      crc_l <= 1'b0;
    end else if (take) begin
      if (nb == 5'h00) cmd0 <= rd_data;
      if (nb == 5'h01) arg <= rd_data;
      nb <= rd_last ? 5'h00 : nb + 5'h01;
      if (rd_last) begin
        len <= nb + 5'h01;
        par_l <= rd_par_err;
        crc_l <= rd_crc_err;
      end
    end
  end

  // Cycles of the current tag answer, eight for each byte
  always_ff @(posedge core_clk) begin
    run <= tg_valid ? run + 9'h001 : 9'h000;
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_nibble_code: assert property (tg_valid && tg_nibble |-> tg_last && tg_data[3:0] inside {4'hA, 4'h1, 4'h0})
    else $error("Nibble answer carries an undefined code");
  a_read_len: assert property ($fell(tg_valid) && cmd0 == 8'h30 && arg <= 8'h29 && !par_l && !crc_l |-> run == 9'h080)
    else $error("Read answer is not sixteen bytes long");
  a_read_range: assert property (tg_valid && cmd0 == 8'h30 && arg > 8'h29 && !par_l && !crc_l |-> tg_nibble && tg_data[3:0] == 4'h0)
    else $error("Read beyond the last page not refused");
  a_read_parity: assert property (tg_valid && cmd0 == 8'h30 && par_l |-> tg_nibble && tg_data[3:0] == 4'h1)
    else $error("Parity error not answered with 1h");
  a_select_sak: assert property (tg_valid && cmd0 == 8'h95 && arg == 8'h70 |-> !tg_nibble && tg_last && tg_data == 8'h00)
    else $error("Select answer is not a single 00h");
  a_anticoll_len: assert property ($fell(tg_valid) && cmd0 == 8'h95 && arg == 8'h20 |-> run == 9'h028)
    else $error("Anticollision answer is not five bytes long");
  a_halt_silent: assert property (halt_ok |-> !tg_valid)
    else $error("Tag answered a good halt");
  a_write_ack: assert property (tg_valid && (cmd0 == 8'hA2 || cmd0 == 8'hA0) |-> tg_nibble && tg_last)
    else $error("Write not answered with a nibble");
  a_half_duplex: assert property (tg_valid |-> !rd_valid)
    else $error("Tag talks during a command");

  c_read: cover property ($fell(tg_valid) && cmd0 == 8'h30);
  c_sak: cover property (tg_valid && cmd0 == 8'h95 && arg == 8'h70);
  c_halt: cover property (halt_ok);
endmodule

// ---- testbench/testbench.sv ----
/*
  Testbench: reader end and tag end joined by one link and a link checker.
  Assumes the shortened reader timing set below; expectations come from a page model.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module testbench;
  typedef struct packed {logic to; logic last; logic nib; logic [7:0] data;} note_t;
  logic core_clk = 0;
  logic rst = 1;
  logic wake = 0;
  logic cmd_valid = 0;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_last = 0;
  logic cmd_par_err = 0;
  logic cmd_crc_err = 0;
  logic cmd_ready, rsp_valid, rsp_last, rsp_nibble, rsp_early, rsp_timeout, active, halted;
  logic [7:0] rsp_data;
  int n_fail = 0;
  int cmp_count = 0;
  note_t exp_q[$];
  note_t e;
  note_t got;
  logic [7:0] f[$];
  logic [7:0] mem [42][4];
  logic [7:0] part2 [5] = '{8'h44, 8'h55, 8'h66, 8'h77, 8'h44 ^ 8'h55 ^ 8'h66 ^ 8'h77};

  // ==========================================================
  // Design, checker and clock
  tag2_link_if lk_if ();
  tag2_reader_end #(.LINK_HALF(4), .ACK_MIN_CYC(20), .TO1_CYC(400), .TO2_CYC(800)) tag2_reader_end_inst (
    .core_clk(core_clk), .rst(rst), .lk(lk_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_data(cmd_data), .cmd_last(cmd_last), .cmd_par_err(cmd_par_err), .cmd_crc_err(cmd_crc_err),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_nibble(rsp_nibble),
    .rsp_early(rsp_early), .rsp_timeout(rsp_timeout));
  tag2_tag_end tag2_tag_end_inst (.core_clk(core_clk), .rst(rst), .lk(lk_if),
    .wake(wake), .active(active), .halted(halted));
  tag2_link_props tag2_link_props_inst (.core_clk(core_clk), .rst(rst), .link_clk(lk_if.link_clk),
    .rd_valid(lk_if.rd_valid), .rd_data(lk_if.rd_data), .rd_last(lk_if.rd_last), .rd_par_err(lk_if.rd_par_err),
    .rd_crc_err(lk_if.rd_crc_err), .tg_valid(lk_if.tg_valid), .tg_data(lk_if.tg_data), .tg_last(lk_if.tg_last),
    .tg_nibble(lk_if.tg_nibble));
  initial forever #4 core_clk = ~core_clk;

  // ==========================================================
  // Tasks
  task automatic note(bit to, bit last, bit nib, logic [7:0] d);
    exp_q.push_back({to, last, nib, d});
  endtask

  // Sends the frame in f, then waits for all noted answers
  task automatic send(bit par = 0, bit crc = 0);
    int w;
    foreach (f[i]) begin
      @(negedge core_clk);
      cmd_valid = 1;
      cmd_data = f[i];
      cmd_last = (i == f.size() - 1);
      cmd_par_err = par;
      cmd_crc_err = crc;
      for (w = 0; w < 100; w++) begin
        @(posedge core_clk);
        if (cmd_ready === 1) break;
      end
    end
    @(negedge core_clk);
    cmd_valid = 0;
    for (w = 0; w < 3000 && exp_q.size() != 0; w++) @(posedge core_clk);
    f.delete();
  endtask

  task automatic exp_read(int a);
    for (int i = 0; i < 16; i++) note(0, i == 15, 0, mem[(a + i / 4) % 42][i % 4]);
  endtask

  task automatic activate();
    @(negedge core_clk);
    wake = 1;
    repeat (4) @(negedge core_clk);
    wake = 0;
    note(0, 1, 0, 8'h00);
    f = '{8'h95, 8'h70, part2[0], part2[1], part2[2], part2[3], part2[4]};
    send(0, 1);
    `CHK(active, 1'b1)
  endtask

  task automatic close_out();
    $display("TB: mismatches %0d, comparisons %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Answer watcher
  assign got = (rsp_timeout === 1) ? 11'h400 : {1'b0, rsp_last, rsp_nibble, rsp_nibble === 1 ? {4'h0, rsp_data[3:0]} : rsp_data};
  always @(posedge core_clk) begin
    if (rsp_valid === 1 || rsp_timeout === 1) begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 'x;
      `CHK(got, e)
    end
  end

  initial begin
    #500us;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out();
  end

  // ==========================================================
  // Scenarios
  initial begin
    logic [7:0] d [4];
    int p;
    void'($urandom(11822));
    foreach (mem[i, j]) mem[i][j] = 8'h00;
    mem[0] = '{8'h11, 8'h22, 8'h33, 8'h88 ^ 8'h11 ^ 8'h22 ^ 8'h33};
    mem[1] = '{part2[0], part2[1], part2[2], part2[3]};
    mem[2][0] = part2[4];
    repeat (16) @(negedge core_clk);
    rst = 0;
    repeat (20) @(negedge core_clk);
    // Full and partial anticollision in ready2
    for (int k = 0; k < 4; k += 2) begin
      f = '{8'h95, 8'h20 + 8'(k * 16)};
      for (int i = 0; i < 5; i++) begin
        if (i < k) f.push_back(part2[i]);
        else note(0, i == 4, 0, part2[i]);
      end
      send();
    end
    activate();
    note(1, 0, 0, 8'h00);
    f = '{8'h95, 8'h20};
    send();
    exp_read(41);
    f = '{8'h30, 8'h29};
    send();
    // Plain and compatibility writes, lowest page first, then read back
    for (int n = 0; n < 4; n++) begin
      p = (n == 0) ? 2 : 3 + $urandom % 39;
      foreach (d[i]) d[i] = 8'($urandom);
      // Keeps the first data byte clear of every command code
      d[0] = d[0] % 8'h20;
      note(0, 1, 1, 8'h0A);
      if (n % 2 == 1) begin
        f = '{8'hA0, 8'(p)};
        send();
        note(0, 1, 1, 8'h0A);
        f = '{d[0], d[1], d[2], d[3]};
        repeat (12) f.push_back(8'h00);
        send();
      end else begin
        f = '{8'hA2, 8'(p), d[0], d[1], d[2], d[3]};
        send();
      end
      // The tag answers within two link periods, well under the shortened minimum
      `CHK(rsp_early, 1'(n % 2))
      mem[p] = d;
      exp_read(p);
      f = '{8'h30, 8'(p)};
      send();
    end
    // Refusals, each followed by a drop to idle
    for (int n = 0; n < 3; n++) begin
      case (n)
        0: f = '{8'hA2, 8'h01, 8'h5A, 8'h5A, 8'h5A, 8'h5A};
        1: f = '{8'h30, 8'h2A};
        default: f = '{8'h30, 8'h00};
      endcase
      note(0, 1, 1, (n == 2) ? 8'h01 : 8'h00);
      send(n == 2, 0);
      `CHK(active, 1'b0)
      note(1, 0, 0, 8'h00);
      f = '{8'h30, 8'h00};
      send();
      activate();
    end
    note(1, 0, 0, 8'h00);
    f = '{8'h50, 8'h00};
    send(1, 0);
    `CHK(halted, 1'b1)
    activate();
    `CHK(halted, 1'b0)
    // Sixteen answer bytes pass the four-word answer FIFO at link pace
    exp_read(0);
    f = '{8'h30, 8'h00};
    send();
    `CHK(exp_q.size(), 0)
    repeat (16) @(negedge core_clk);
    `CHK(lk_if.tg_valid, 1'b0)
    `CHK(active, 1'b1)
    close_out();
  end
endmodule
